// ==== rtl/tlic_ext_req.sv ====
// One external request input: synchroniser, edge detect and request flag.
module tlic_ext_req
   import tlic_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pin_n,
   input wire logic i_sample,
   input wire logic i_edge_select,
   input wire logic i_vector_clear,
   input wire logic i_sw_write,
   input wire logic i_sw_value,
   output logic o_flag
);
   logic sync1;
   logic sync2;
   logic last_sample;
   logic edge_flag;
   logic fell;
   logic next_edge_flag;

   // Two-stage synchroniser; only sync2 is read by logic.
   always_ff @(posedge i_clk) begin
      sync1 <= i_pin_n;
      sync2 <= sync1;
   end

   // Pin sample taken once per machine cycle.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         last_sample <= 1'b1;
      end else if (i_sample) begin
         last_sample <= sync2;
      end
   end

   // High in one sample and low in the next sets the edge flag.
   assign fell = i_sample & last_sample & ~sync2;
   // The set wins over a vector or software clear in the same cycle.
   assign next_edge_flag = fell ? 1'b1 :
                           i_sw_write ? i_sw_value :
                           i_vector_clear ? 1'b0 : edge_flag;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         edge_flag <= 1'b0;
      end else begin
         edge_flag <= next_edge_flag;
      end
   end

   // Level mode follows the inverted pin and is never cleared here.
   assign o_flag = i_edge_select ? edge_flag : ~sync2;
endmodule

// ==== rtl/tlic_machine_cycle.sv ====
// Machine-cycle state divider producing the sample and poll strobes.
module tlic_machine_cycle
   import tlic_pkg::*;
#(
   parameter int STATES = 12
) (
   input wire logic i_clk,
   input wire logic i_srst,
   output logic o_sample,
   output logic o_poll
);
   logic [3:0] phase;
   logic at_last;

   assign at_last = (phase == 4'(STATES - 1));

   // Phase counter across one machine cycle.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         phase <= 4'h0;
      end else begin
         phase <= at_last ? 4'h0 : phase + 4'h1;
      end
   end

   // Sample near the end of the cycle, poll two states later in its last state.
   assign o_sample = (phase == 4'(STATES - 3));
   assign o_poll = at_last;
endmodule

// ==== rtl/tlic_pkg.sv ====
// Package of constants for the two-level interrupt controller.
package tlic_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_SOURCE_ENABLE = 4'h0;
   localparam logic [3:0] ADDR_LEVEL_SELECT = 4'h1;
   localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_PERIPH_FLAGS = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int NUM_SRC = 6;
   localparam int GLOBAL_ENABLE_BIT = 7;
   localparam logic [7:0] LEVEL_SELECT_MASK = 8'h3f;
   localparam logic [7:0] SOURCE_ENABLE_RESET = 8'h00;
   localparam logic [7:0] LEVEL_SELECT_RESET = 8'h00;
   // Timer control fields: edge selects and request flags.
   localparam int TC_EXT0_EDGE = 0;
   localparam int TC_EXT0_FLAG = 1;
   localparam int TC_EXT1_EDGE = 2;
   localparam int TC_EXT1_FLAG = 3;
   localparam int TC_T0_FLAG = 5;
   localparam int TC_T1_FLAG = 7;
   // Peripheral flag register fields.
   localparam int PF_RX = 0;
   localparam int PF_TX = 1;
   localparam int PF_T2_OVF = 2;
   localparam int PF_T2_EXT = 3;
   // Source indices in polling order.
   localparam logic [2:0] SRC_EXT0 = 3'h0;
   localparam logic [2:0] SRC_T0 = 3'h1;
   localparam logic [2:0] SRC_EXT1 = 3'h2;
   localparam logic [2:0] SRC_T1 = 3'h3;
   localparam logic [2:0] SRC_SERIAL = 3'h4;
   localparam logic [2:0] SRC_T2 = 3'h5;
   // Vector address of source n is VECTOR_BASE + n * VECTOR_STEP.
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam logic [15:0] VECTOR_STEP = 16'h0008;
endpackage

// ==== rtl/tlic_top.sv ====
// Two-level interrupt controller top: flags, masks, priority and vector handshake.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
module tlic_top
   import tlic_pkg::*;
#(
   parameter bit EXTENDED = 1'b1
) (
   input wire logic I_CLK_SYS,
   input wire logic I_SRST,
   // Register port.
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   // Request pins, active low.
   input wire logic I_EXT0_REQUEST_PIN_N,
   input wire logic I_EXT1_REQUEST_PIN_N,
   // Peripheral flag set pulses.
   input wire logic I_TIMER0_ROLLOVER,
   input wire logic I_TIMER1_ROLLOVER,
   input wire logic I_RX_DONE,
   input wire logic I_TX_DONE,
   input wire logic I_TIMER2_ROLLOVER,
   input wire logic I_TIMER2_EXTERNAL,
   // Sequencer side.
   input wire logic I_LAST_CYCLE,
   input wire logic I_SPECIAL_INSTR,
   input wire logic I_VECTOR_ACK,
   input wire logic I_RETURN_FROM_INTERRUPT,
   output logic O_VECTOR_REQ,
   output logic [2:0] O_VECTOR_INDEX,
   output logic [15:0] O_VECTOR_ADDR,
   output logic [1:0] O_IN_PROGRESS
);
   // ------------------------------------------------------------
   // Timing strobes
   // ------------------------------------------------------------
   logic sample;
   logic poll;

   tlic_machine_cycle u_cycle (
      .i_clk(I_CLK_SYS),
      .i_srst(I_SRST),
      .o_sample(sample),
      .o_poll(poll)
   );

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   logic wr_enable;
   logic wr_level;
   logic wr_timer;
   logic wr_periph;
   assign wr_enable = I_WR & (I_ADDR == ADDR_SOURCE_ENABLE);
   assign wr_level = I_WR & (I_ADDR == ADDR_LEVEL_SELECT);
   assign wr_timer = I_WR & (I_ADDR == ADDR_TIMER_CONTROL);
   assign wr_periph = I_WR & (I_ADDR == ADDR_PERIPH_FLAGS);

   logic [7:0] source_enable_reg;
   logic [7:0] level_select_reg;
   logic ext0_edge_select;
   logic ext1_edge_select;

   // Software-written control registers.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         source_enable_reg <= SOURCE_ENABLE_RESET;
         level_select_reg <= LEVEL_SELECT_RESET;
         ext0_edge_select <= 1'b0;
         ext1_edge_select <= 1'b0;
      end else begin
         if (wr_enable) begin
            source_enable_reg <= I_WDATA;
         end
         if (wr_level) begin
            level_select_reg <= I_WDATA & LEVEL_SELECT_MASK;
         end
         if (wr_timer) begin
            ext0_edge_select <= I_WDATA[TC_EXT0_EDGE];
            ext1_edge_select <= I_WDATA[TC_EXT1_EDGE];
         end
      end
   end

   // ------------------------------------------------------------
   // Request flags
   // ------------------------------------------------------------
   logic vector_fire;
   logic [2:0] vec_index;
   logic clr_ext0;
   logic clr_ext1;
   logic clr_t0;
   logic clr_t1;
   assign vector_fire = O_VECTOR_REQ & I_VECTOR_ACK;
   assign clr_ext0 = vector_fire & (vec_index == SRC_EXT0) & ext0_edge_select;
   assign clr_ext1 = vector_fire & (vec_index == SRC_EXT1) & ext1_edge_select;
   assign clr_t0 = vector_fire & (vec_index == SRC_T0);
   assign clr_t1 = vector_fire & (vec_index == SRC_T1);

   logic ext0_request_flag;
   logic ext1_request_flag;

   tlic_ext_req u_ext0 (
      .i_clk(I_CLK_SYS),
      .i_srst(I_SRST),
      .i_pin_n(I_EXT0_REQUEST_PIN_N),
      .i_sample(sample),
      .i_edge_select(ext0_edge_select),
      .i_vector_clear(clr_ext0),
      .i_sw_write(wr_timer),
      .i_sw_value(I_WDATA[TC_EXT0_FLAG]),
      .o_flag(ext0_request_flag)
   );

   tlic_ext_req u_ext1 (
      .i_clk(I_CLK_SYS),
      .i_srst(I_SRST),
      .i_pin_n(I_EXT1_REQUEST_PIN_N),
      .i_sample(sample),
      .i_edge_select(ext1_edge_select),
      .i_vector_clear(clr_ext1),
      .i_sw_write(wr_timer),
      .i_sw_value(I_WDATA[TC_EXT1_FLAG]),
      .o_flag(ext1_request_flag)
   );

   logic timer0_overflow_flag;
   logic timer1_overflow_flag;
   logic rx_done_flag;
   logic tx_done_flag;
   logic timer2_overflow_flag;
   logic timer2_external_flag;
   logic next_t0;
   logic next_t1;
   logic next_rx;
   logic next_tx;
   logic next_t2o;
   logic next_t2e;

   // Hardware set wins over any clear; software writes act like hardware.
   assign next_t0 = I_TIMER0_ROLLOVER | (wr_timer ? I_WDATA[TC_T0_FLAG] :
                    (timer0_overflow_flag & ~clr_t0));
   assign next_t1 = I_TIMER1_ROLLOVER | (wr_timer ? I_WDATA[TC_T1_FLAG] :
                    (timer1_overflow_flag & ~clr_t1));
   // No vector clear on serial or timer2 flags.
   assign next_rx = I_RX_DONE | (wr_periph ? I_WDATA[PF_RX] : rx_done_flag);
   assign next_tx = I_TX_DONE | (wr_periph ? I_WDATA[PF_TX] : tx_done_flag);
   assign next_t2o = I_TIMER2_ROLLOVER | (wr_periph ? I_WDATA[PF_T2_OVF] :
                     timer2_overflow_flag);
   assign next_t2e = I_TIMER2_EXTERNAL | (wr_periph ? I_WDATA[PF_T2_EXT] :
                     timer2_external_flag);

   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         timer0_overflow_flag <= 1'b0;
         timer1_overflow_flag <= 1'b0;
         rx_done_flag <= 1'b0;
         tx_done_flag <= 1'b0;
         timer2_overflow_flag <= 1'b0;
         timer2_external_flag <= 1'b0;
      end else begin
         timer0_overflow_flag <= next_t0;
         timer1_overflow_flag <= next_t1;
         rx_done_flag <= next_rx;
         tx_done_flag <= next_tx;
         timer2_overflow_flag <= next_t2o & EXTENDED;
         timer2_external_flag <= next_t2e & EXTENDED;
      end
   end

   // ------------------------------------------------------------
   // Sampling and priority resolution
   // ------------------------------------------------------------
   logic [NUM_SRC-1:0] raw_req;
   logic [NUM_SRC-1:0] sampled;
   assign raw_req[SRC_EXT0] = ext0_request_flag;
   assign raw_req[SRC_T0] = timer0_overflow_flag;
   assign raw_req[SRC_EXT1] = ext1_request_flag;
   assign raw_req[SRC_T1] = timer1_overflow_flag;
   assign raw_req[SRC_SERIAL] = rx_done_flag | tx_done_flag;
   assign raw_req[SRC_T2] = EXTENDED & (timer2_overflow_flag | timer2_external_flag);

   // Fresh sample each machine cycle; nothing older is remembered.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         sampled <= '0;
      end else if (sample) begin
         sampled <= raw_req;
      end
   end

   logic [NUM_SRC-1:0] enabled;
   logic [NUM_SRC-1:0] hi_req;
   logic [NUM_SRC-1:0] lo_req;
   assign enabled = sampled & source_enable_reg[NUM_SRC-1:0]
                    & {NUM_SRC{source_enable_reg[GLOBAL_ENABLE_BIT]}};
   assign hi_req = enabled & level_select_reg[NUM_SRC-1:0];
   assign lo_req = enabled & ~level_select_reg[NUM_SRC-1:0];

   // Lowest set bit wins, which is the fixed polling order.
   function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   logic hi_active;
   logic lo_active;
   logic hi_ok;
   logic lo_ok;
   logic pick_hi;
   logic win_valid;
   logic [2:0] win_index;
   logic not_blocked;
   assign hi_ok = (|hi_req) & ~hi_active;
   assign lo_ok = (|lo_req) & ~hi_active & ~lo_active;
   assign pick_hi = hi_ok;
   assign win_index = pick_hi ? first_set(hi_req) : first_set(lo_req);
   assign win_valid = hi_ok | lo_ok;
   assign not_blocked = I_LAST_CYCLE & ~I_SPECIAL_INSTR;

   // ------------------------------------------------------------
   // Vector request and in-progress tracking
   // ------------------------------------------------------------
   logic vec_level_hi;
   logic request_now;
   assign request_now = poll & win_valid & not_blocked & ~O_VECTOR_REQ
                        & ~wr_enable & ~wr_level;
   assign vec_index = O_VECTOR_INDEX;

   // Request stands until acknowledged by the sequencer.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         O_VECTOR_REQ <= 1'b0;
         O_VECTOR_INDEX <= 3'h0;
         O_VECTOR_ADDR <= VECTOR_BASE;
         vec_level_hi <= 1'b0;
      end else if (request_now) begin
         O_VECTOR_REQ <= 1'b1;
         O_VECTOR_INDEX <= win_index;
         O_VECTOR_ADDR <= VECTOR_BASE + VECTOR_STEP * {13'h0000, win_index};
         vec_level_hi <= pick_hi;
      end else if (I_VECTOR_ACK) begin
         O_VECTOR_REQ <= 1'b0;
      end
   end

   // High routine returns first since it is the one running if both are set.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         hi_active <= 1'b0;
         lo_active <= 1'b0;
      end else if (vector_fire) begin
         hi_active <= hi_active | vec_level_hi;
         lo_active <= lo_active | ~vec_level_hi;
      end else if (I_RETURN_FROM_INTERRUPT) begin
         if (hi_active) begin
            hi_active <= 1'b0;
         end else begin
            lo_active <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         O_IN_PROGRESS <= 2'h0;
      end else begin
         O_IN_PROGRESS <= {hi_active, lo_active};
      end
   end

   // ------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------
   logic [7:0] rd_mux;
   logic [7:0] timer_view;
   assign timer_view = {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0,
                        ext1_request_flag, ext1_edge_select,
                        ext0_request_flag, ext0_edge_select};
   assign rd_mux = (I_ADDR == ADDR_SOURCE_ENABLE) ? source_enable_reg :
                   (I_ADDR == ADDR_LEVEL_SELECT) ? level_select_reg :
                   (I_ADDR == ADDR_TIMER_CONTROL) ? timer_view :
                   (I_ADDR == ADDR_PERIPH_FLAGS) ? {4'h0, timer2_external_flag,
                      timer2_overflow_flag, tx_done_flag, rx_done_flag} :
                   (I_ADDR == ADDR_STATUS) ? {2'h0, sampled} : 8'h00;

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         O_RDATA <= 8'h00;
      end else begin
         O_RDATA <= I_RD ? rd_mux : 8'h00;
      end
   end
endmodule

// ==== verif/tb_tlic_top.sv ====
// Self-checking testbench of the two-level interrupt controller.
module tb_tlic_top
   import tlic_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pin0 = 1'b1;
   logic pin1 = 1'b1;
   logic [5:0] hw = 6'h00;
   logic busy = 1'b0;
   logic special = 1'b0;
   logic ret_cmd = 1'b0;
   logic [3:0] delay = 4'h0;
   logic ack, ret, last, spec, req;
   logic [7:0] rdata;
   logic [2:0] idx;
   logic [15:0] vaddr;
   logic [1:0] in_prog;
   int failures = 0;
   int n_compared = 0;
   logic [3:0] set_a [6] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3};
   logic [7:0] set_d [6] = '{8'h07, 8'h25, 8'h0d, 8'h85, 8'h01, 8'h04};
   logic [7:0] left_d [6] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'h04};
   // The clock runs at 10 MHz.
   always #50 clk = ~clk;
   // The design, with its peripheral pulses packed in one vector.
   tlic_top #(.EXTENDED(1'b1)) dut (
      .I_CLK_SYS(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_EXT0_REQUEST_PIN_N(pin0),
      .I_EXT1_REQUEST_PIN_N(pin1), .I_TIMER0_ROLLOVER(hw[0]), .I_TIMER1_ROLLOVER(hw[1]),
      .I_RX_DONE(hw[2]), .I_TX_DONE(hw[3]), .I_TIMER2_ROLLOVER(hw[4]),
      .I_TIMER2_EXTERNAL(hw[5]), .I_LAST_CYCLE(last), .I_SPECIAL_INSTR(spec),
      .I_VECTOR_ACK(ack), .I_RETURN_FROM_INTERRUPT(ret), .O_VECTOR_REQ(req),
      .O_VECTOR_INDEX(idx), .O_VECTOR_ADDR(vaddr), .O_IN_PROGRESS(in_prog)
   );
   tlic_seq_model seq (
      .i_clk(clk), .i_srst(srst), .i_req(req), .i_ack_delay(delay), .i_ret_cmd(ret_cmd),
      .i_busy(busy), .i_special(special), .o_ack(ack), .o_ret(ret), .o_last(last),
      .o_special(spec)
   );
   // ------------------------------------------------------------
   // Access and comparison tasks
   // ------------------------------------------------------------
   // Compares one value and reports a mismatch at once.
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle register write.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One-cycle register read; the data stand in the following cycle only.
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp(what, {8'h00, exp}, {8'h00, rdata});
   endtask
   // Waits a bounded time for a vector, checks it, then lets the sequencer take it.
   task automatic take_vector(input logic [2:0] i, input logic [1:0] exp_ip);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (req !== 1'b1 && k < 40);
      if (req !== 1'b1) begin
         failures++;
         $display("CHECK FAILED vector request expected 1 seen %b", req);
         end_sim();
      end else begin
         cmp("vector index", {13'h0000, i}, {13'h0000, idx});
         cmp("vector address", 16'h0003 + 16'(i) * 16'h0008, vaddr);
         repeat (20) @(posedge clk);
         #1;
         cmp("in progress", {14'h0000, exp_ip}, {14'h0000, in_prog});
      end
   endtask
   // Checks that no vector is requested for a number of cycles.
   task automatic no_vector(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1;
         seen = seen | (req !== 1'b0);
      end
      cmp("no vector", 16'h0000, {15'h0000, seen});
   endtask
   // Return from the routine, then a short settling gap.
   task automatic do_ret();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Raises peripheral set pulses for one cycle.
   task automatic pulse(input logic [5:0] p);
      @(posedge clk);
      hw <= p;
      @(posedge clk);
      hw <= 6'h00;
   endtask
   task automatic done(input string s);
      $display("test %0s finished", s);
   endtask
   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Main sequence: reset, registers, sources, nesting, masking and pins.
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rd_chk("enable reset", ADDR_SOURCE_ENABLE, SOURCE_ENABLE_RESET);
      cmp("reset vector request", 16'h0000, {15'h0000, req});
      cmp("reset vector address", 16'h0003, vaddr);
      cmp("reset in progress", 16'h0000, {14'h0000, in_prog});
      rd_chk("level reset", ADDR_LEVEL_SELECT, LEVEL_SELECT_RESET);
      wr_reg(ADDR_LEVEL_SELECT, 8'hff);
      rd_chk("level reserved", ADDR_LEVEL_SELECT, 8'h3f);
      wr_reg(4'hf, 8'hff);
      rd_chk("unmapped", 4'hf, 8'h00);
      done("registers");
      wr_reg(ADDR_LEVEL_SELECT, 8'h00);
      wr_reg(ADDR_SOURCE_ENABLE, 8'hbf);
      for (int i = 0; i < 6; i++) begin
         wr_reg(set_a[i], set_d[i]);
         take_vector(i[2:0], 2'b01);
         rd_chk("flag after vector", set_a[i], left_d[i]);
         wr_reg(ADDR_PERIPH_FLAGS, 8'h00);
         do_ret();
      end
      done("vector table");
      delay <= 4'h9;
      pulse(6'h3f);
      take_vector(SRC_T0, 2'b01);
      no_vector(30);
      wr_reg(ADDR_LEVEL_SELECT, 8'h18);
      take_vector(SRC_T1, 2'b11);
      no_vector(30);
      do_ret();
      take_vector(SRC_SERIAL, 2'b11);
      rd_chk("peripheral flags", ADDR_PERIPH_FLAGS, 8'h0f);
      rd_chk("timer flags", ADDR_TIMER_CONTROL, 8'h05);
      wr_reg(ADDR_PERIPH_FLAGS, 8'h00);
      do_ret();
      do_ret();
      done("priority");
      wr_reg(ADDR_SOURCE_ENABLE, 8'h3f);
      pulse(6'h01);
      no_vector(30);
      rd_chk("sampled requests", ADDR_STATUS, 8'h02);
      wr_reg(ADDR_SOURCE_ENABLE, 8'hbd);
      no_vector(30);
      busy <= 1'b1;
      wr_reg(ADDR_SOURCE_ENABLE, 8'hbf);
      no_vector(30);
      busy <= 1'b0;
      special <= 1'b1;
      no_vector(30);
      special <= 1'b0;
      take_vector(SRC_T0, 2'b01);
      do_ret();
      done("masking");
      wr_reg(ADDR_TIMER_CONTROL, 8'h01);
      pin0 <= 1'b0;
      take_vector(SRC_EXT0, 2'b01);
      rd_chk("edge flag", ADDR_TIMER_CONTROL, 8'h01);
      do_ret();
      no_vector(30);
      pin1 <= 1'b0;
      take_vector(SRC_EXT1, 2'b01);
      rd_chk("level flag", ADDR_TIMER_CONTROL, 8'h09);
      pin1 <= 1'b1;
      repeat (30) @(posedge clk);
      do_ret();
      no_vector(30);
      done("external pins");
      end_sim();
   end
endmodule

// ==== verif/tlic_properties.sv ====
// Concurrent checks of the vector handshake, masking and nesting at the top ports.
module tlic_properties
   import tlic_pkg::*;
#(
   parameter bit EXTENDED = 1'b1
) (
   input wire logic I_CLK_SYS,
   input wire logic I_SRST,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_LAST_CYCLE,
   input wire logic I_SPECIAL_INSTR,
   input wire logic I_VECTOR_ACK,
   input wire logic I_RETURN_FROM_INTERRUPT,
   input wire logic O_VECTOR_REQ,
   input wire logic [2:0] O_VECTOR_INDEX,
   input wire logic [15:0] O_VECTOR_ADDR,
   input wire logic [1:0] O_IN_PROGRESS
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] en;
   logic [7:0] lvl;
   // Shadow copies of the enable and level registers, taken from the write port.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         en <= SOURCE_ENABLE_RESET;
         lvl <= LEVEL_SELECT_RESET;
      end else if (I_WR && I_ADDR == ADDR_SOURCE_ENABLE) begin
         en <= I_WDATA;
      end else if (I_WR && I_ADDR == ADDR_LEVEL_SELECT) begin
         lvl <= I_WDATA;
      end
   end
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SRST);
   // A request that has just been raised, and an accepted vector call.
   sequence s_new_req;
      !O_VECTOR_REQ ##1 O_VECTOR_REQ;
   endsequence
   sequence s_ack;
      O_VECTOR_REQ && I_VECTOR_ACK;
   endsequence
   a_addr_from_index: assert property (
      O_VECTOR_REQ |-> O_VECTOR_ADDR == {10'h000, O_VECTOR_INDEX, 3'h3})
      else $error("vector address does not match index");
   a_index_in_range: assert property (
      O_VECTOR_REQ |-> O_VECTOR_INDEX <= (EXTENDED ? 3'h5 : 3'h4))
      else $error("vector index outside the source set");
   a_req_holds_steady: assert property (
      O_VECTOR_REQ && !I_VECTOR_ACK |=> O_VECTOR_REQ && $stable(O_VECTOR_INDEX))
      else $error("vector request dropped or changed before acknowledge");
   a_req_ends_on_ack: assert property (
      s_ack |=> !O_VECTOR_REQ)
      else $error("vector request stayed after acknowledge");
   a_ack_marks_busy: assert property (
      s_ack |-> ##2 O_IN_PROGRESS != 2'b00)
      else $error("no level marked in progress after acknowledge");
   a_high_blocks_all: assert property (
      s_new_req |-> !O_IN_PROGRESS[1])
      else $error("vector raised during a high routine");
   a_low_needs_high: assert property (
      s_new_req ##0 O_IN_PROGRESS[0] |-> lvl[O_VECTOR_INDEX])
      else $error("low request nested in a low routine");
   a_enable_masks: assert property (
      s_new_req |-> en[GLOBAL_ENABLE_BIT] && en[O_VECTOR_INDEX])
      else $error("vector raised for a masked source");
   a_block_mid_instr: assert property (
      s_new_req |-> $past(I_LAST_CYCLE) && !$past(I_SPECIAL_INSTR))
      else $error("vector raised while the poll was blocked");
   a_ret_clears_low: assert property (
      I_RETURN_FROM_INTERRUPT && O_IN_PROGRESS == 2'b01 |-> ##2 O_IN_PROGRESS == 2'b00)
      else $error("return did not end the low routine");
   a_ret_clears_high: assert property (
      I_RETURN_FROM_INTERRUPT && O_IN_PROGRESS == 2'b11 |-> ##2 O_IN_PROGRESS == 2'b01)
      else $error("return did not end the high routine first");
endmodule

bind tlic_top tlic_properties #(.EXTENDED(EXTENDED)) u_props (
   .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WR(I_WR), .I_LAST_CYCLE(I_LAST_CYCLE), .I_SPECIAL_INSTR(I_SPECIAL_INSTR),
   .I_VECTOR_ACK(I_VECTOR_ACK), .I_RETURN_FROM_INTERRUPT(I_RETURN_FROM_INTERRUPT),
   .O_VECTOR_REQ(O_VECTOR_REQ), .O_VECTOR_INDEX(O_VECTOR_INDEX),
   .O_VECTOR_ADDR(O_VECTOR_ADDR), .O_IN_PROGRESS(O_IN_PROGRESS)
);

// ==== verif/tlic_seq_model.sv ====
// Behavioural model of the instruction sequencer facing the controller.
module tlic_seq_model (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_req,
   input wire logic [3:0] i_ack_delay,
   input wire logic i_ret_cmd,
   input wire logic i_busy,
   input wire logic i_special,
   output logic o_ack,
   output logic o_ret,
   output logic o_last,
   output logic o_special
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_cnt;
   // Instruction boundary and blocking instruction as seen by the poll.
   assign o_last = !i_busy;
   assign o_special = i_special;
   // Acknowledge each pending vector once, after a chosen delay, and forward returns.
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_req || o_ack) begin
         wait_cnt <= 4'h0;
         o_ack <= 1'b0;
      end else if (wait_cnt == i_ack_delay) begin
         o_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
      o_ret <= i_ret_cmd && !i_srst;
   end
endmodule
